// ### pkg/irq_pwr_consts.vh
// Constants for the interrupt priority and power control block.
// Assumes inclusion by bare name from the design files.
`ifndef IRQ_PWR_CONSTS_VH
`define IRQ_PWR_CONSTS_VH

// Special function register addresses
`define SFR_IRQ_ENABLE_PRIMARY   8'hA8
`define SFR_IRQ_ENABLE_SECONDARY 8'hA7
`define SFR_IRQ_PRIORITY_PRIMARY 8'hB8
`define SFR_IRQ_PRIORITY_SECOND  8'hB7
`define SFR_POWER_CONTROL        8'h87

// Writable bit masks, unused bits read zero
`define MASK_ENABLE_PRIMARY      8'hBF
`define MASK_ENABLE_SECONDARY    8'h12
`define MASK_PRIORITY_PRIMARY    8'h3F
`define MASK_PRIORITY_SECONDARY  8'h12

// Reset values
`define RST_ENABLE_PRIMARY       8'h00
`define RST_ENABLE_SECONDARY     8'h00
`define RST_PRIORITY_PRIMARY     8'h00
`define RST_PRIORITY_SECONDARY   8'h00
`define RST_POWER_CONTROL        8'h00

// Primary enable / priority field positions
`define BIT_GLOBAL_IRQ_EN        7
`define BIT_TMR2                 5
`define BIT_SERIAL1              4
`define BIT_TMR1                 3
`define BIT_EXT1                 2
`define BIT_TMR0                 1
`define BIT_EXT0                 0
// Secondary enable / priority field positions
`define BIT_SERIAL2              4
`define BIT_TWOWIRE              1

// Power control field positions
`define BIT_SERIAL1_BAUD_DOUBLE  7
`define BIT_SERIAL2_BAUD_DOUBLE  6
`define BIT_LOWVOLT_RST_DISABLE  5
`define BIT_ADC_IRQ_EN           4
`define BIT_SERIAL2_RX_CLK_SEL   3
`define BIT_SERIAL2_TX_CLK_SEL   2
`define BIT_POWERDOWN_REQ        1
`define BIT_IDLE_REQ             0

// Source index in poll order 0 (first) to 7 (last)
`define SRC_EXT0                 3'd0
`define SRC_SERIAL2              3'd1
`define SRC_TMR0                 3'd2
`define SRC_TWOWIRE              3'd3
`define SRC_EXT1                 3'd4
`define SRC_TMR1                 3'd5
`define SRC_SERIAL1              3'd6
`define SRC_TMR2                 3'd7
`define NUM_SRC                  8

// Vector addresses
`define VEC_EXT0                 16'h0003
`define VEC_TMR0                 16'h000B
`define VEC_EXT1                 16'h0013
`define VEC_TMR1                 16'h001B
`define VEC_SERIAL1              16'h0023
`define VEC_TMR2                 16'h002B
`define VEC_TWOWIRE              16'h0043
`define VEC_SERIAL2              16'h004B

// Timing, in core clocks; restart length in machine cycles
`define CLK_PER_MCYCLE           4'd12
`define SAMPLE_PHASE             4'd9
`define RESTART_MCYCLES          2'd3

`endif

// ### hw/irq_poll_pick.v
// Fixed-order picker: lowest-index set request wins.
// Assumes requests already qualified by enable and level.
`timescale 1ns/1ps
`default_nettype none
`include "irq_pwr_consts.vh"

module irq_poll_pick (
    input  wire [7:0] req,
    output reg        hit,
    output reg  [2:0] idx
);

    integer i;

    always @* begin
        hit = 1'b0;
        idx = 3'h0;
        // Scan from last to first so the earliest set source wins
        for (i = `NUM_SRC - 1; i >= 0; i = i - 1) begin
            if (req[i]) begin
                hit = 1'b1;
                idx = i[2:0];
            end
        end
    end

endmodule // irq_poll_pick

`default_nettype wire

// ### hw/irq_priority_and_power_ctrl.v
// Interrupt arbitration, in-progress tracking and power-saving control.
// Assumes the core sequencer supplies last-machine-cycle and
// instruction status, and pins are already synchronised upstream.
`timescale 1ns/1ps
`default_nettype none
`include "irq_pwr_consts.vh"

module irq_priority_and_power_ctrl (
    input  wire        clk,
    input  wire        nrst,
    // Special function register port
    input  wire [7:0]  sfr_addr,
    input  wire [7:0]  sfr_wdata,
    input  wire        sfr_wr,
    input  wire        sfr_rd,
    output reg  [7:0]  sfr_rdata,
    output wire        sfr_hit,
    // Core sequencer status
    input  wire        mcycle_last,
    input  wire        instr_done,
    input  wire        irq_return_instr,
    input  wire        sub_return_instr,
    input  wire        internal_rst,
    // Peripheral request flags, poll order
    input  wire [7:0]  irq_flags,
    // Call request to the sequencer
    output reg         long_call_instr,
    output reg  [15:0] call_vector,
    output reg  [2:0]  call_source,
    output wire        push_pc_only,
    output reg         pop_pc_two,
    // Power and peripheral controls
    output wire        cpu_halt,
    output wire        osc_stop,
    output wire        pwm_disable,
    output wire        twowire_disable,
    output wire        lowvolt_detect_en,
    output wire        lowvolt_reset_disable,
    output wire        adc_irq_en,
    output wire        serial1_baud_double,
    output wire        serial2_baud_double,
    output wire        serial2_rx_clk_sel,
    output wire        serial2_tx_clk_sel,
    output wire        cpu_run_en,
    output wire [1:0]  in_progress
);

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function [15:0] vec_of;
        input [2:0] src;
        begin
            case (src)
                `SRC_EXT0:    vec_of = `VEC_EXT0;
                `SRC_SERIAL2: vec_of = `VEC_SERIAL2;
                `SRC_TMR0:    vec_of = `VEC_TMR0;
                `SRC_TWOWIRE: vec_of = `VEC_TWOWIRE;
                `SRC_EXT1:    vec_of = `VEC_EXT1;
                `SRC_TMR1:    vec_of = `VEC_TMR1;
                `SRC_SERIAL1: vec_of = `VEC_SERIAL1;
                default:      vec_of = `VEC_TMR2;
            endcase
        end
    endfunction

    function is_irq_reg;
        input [7:0] a;
        begin
            is_irq_reg = (a == `SFR_IRQ_ENABLE_PRIMARY)
                       | (a == `SFR_IRQ_ENABLE_SECONDARY)
                       | (a == `SFR_IRQ_PRIORITY_PRIMARY)
                       | (a == `SFR_IRQ_PRIORITY_SECOND);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers

    reg [7:0] irq_enable_primary_q;
    reg [7:0] irq_enable_secondary_q;
    reg [7:0] irq_priority_primary_q;
    reg [7:0] irq_priority_secondary_q;
    reg [7:0] power_control_q;

    wire wr_ie  = sfr_wr & (sfr_addr == `SFR_IRQ_ENABLE_PRIMARY);
    wire wr_iea = sfr_wr & (sfr_addr == `SFR_IRQ_ENABLE_SECONDARY);
    wire wr_ip  = sfr_wr & (sfr_addr == `SFR_IRQ_PRIORITY_PRIMARY);
    wire wr_ipa = sfr_wr & (sfr_addr == `SFR_IRQ_PRIORITY_SECOND);
    wire wr_pc  = sfr_wr & (sfr_addr == `SFR_POWER_CONTROL);

    assign sfr_hit = is_irq_reg(sfr_addr)
                   | (sfr_addr == `SFR_POWER_CONTROL);

    reg idle_wake;

    always @(posedge clk) begin
        if (!nrst) begin
            irq_enable_primary_q     <= `RST_ENABLE_PRIMARY;
            irq_enable_secondary_q   <= `RST_ENABLE_SECONDARY;
            irq_priority_primary_q   <= `RST_PRIORITY_PRIMARY;
            irq_priority_secondary_q <= `RST_PRIORITY_SECONDARY;
            power_control_q          <= `RST_POWER_CONTROL;
        end else begin
            if (wr_ie)
                irq_enable_primary_q <= sfr_wdata & `MASK_ENABLE_PRIMARY;
            if (wr_iea)
                irq_enable_secondary_q <= sfr_wdata & `MASK_ENABLE_SECONDARY;
            if (wr_ip)
                irq_priority_primary_q <= sfr_wdata & `MASK_PRIORITY_PRIMARY;
            if (wr_ipa)
                irq_priority_secondary_q <=
                    sfr_wdata & `MASK_PRIORITY_SECONDARY;
            // Wake clear beats a same-cycle write so the wake is not lost
            if (wr_pc)
                power_control_q <= sfr_wdata;
            if (idle_wake)
                power_control_q[`BIT_IDLE_REQ] <= 1'b0;
        end
    end

    always @* begin
        case (sfr_addr)
            `SFR_IRQ_ENABLE_PRIMARY:   sfr_rdata = irq_enable_primary_q;
            `SFR_IRQ_ENABLE_SECONDARY: sfr_rdata = irq_enable_secondary_q;
            `SFR_IRQ_PRIORITY_PRIMARY: sfr_rdata = irq_priority_primary_q;
            `SFR_IRQ_PRIORITY_SECOND:  sfr_rdata = irq_priority_secondary_q;
            `SFR_POWER_CONTROL:        sfr_rdata = power_control_q;
            default:                   sfr_rdata = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Machine cycle phase

    reg [3:0] phase_q;
    wire      sample_en = (phase_q == `SAMPLE_PHASE);
    wire      mcyc_end  = (phase_q == `CLK_PER_MCYCLE - 4'd1);

    always @(posedge clk) begin
        // Parked while the oscillator is stopped in power-down
        if (!nrst || power_control_q[`BIT_POWERDOWN_REQ])
            phase_q <= 4'h0;
        else if (mcyc_end)
            phase_q <= 4'h0;
        else
            phase_q <= phase_q + 4'd1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-source enable and level in poll order

    wire [7:0] src_en = {
        irq_enable_primary_q[`BIT_TMR2],
        irq_enable_primary_q[`BIT_SERIAL1],
        irq_enable_primary_q[`BIT_TMR1],
        irq_enable_primary_q[`BIT_EXT1],
        irq_enable_secondary_q[`BIT_TWOWIRE],
        irq_enable_primary_q[`BIT_TMR0],
        irq_enable_secondary_q[`BIT_SERIAL2],
        irq_enable_primary_q[`BIT_EXT0]};

    wire [7:0] src_hi = {
        irq_priority_primary_q[`BIT_TMR2],
        irq_priority_primary_q[`BIT_SERIAL1],
        irq_priority_primary_q[`BIT_TMR1],
        irq_priority_primary_q[`BIT_EXT1],
        irq_priority_secondary_q[`BIT_TWOWIRE],
        irq_priority_primary_q[`BIT_TMR0],
        irq_priority_secondary_q[`BIT_SERIAL2],
        irq_priority_primary_q[`BIT_EXT0]};

    ////////////////////////////////////////////////////////////////////////
    // Sample and poll

    reg [7:0] sampled_q;
    wire      global_en = irq_enable_primary_q[`BIT_GLOBAL_IRQ_EN];

    // Resampled once per machine cycle at SAMPLE_PHASE; nothing carries a missed request over
    always @(posedge clk) begin
        if (!nrst)
            sampled_q <= 8'h00;
        else if (sample_en)
            sampled_q <= irq_flags;
    end

    wire [7:0] live     = sampled_q & src_en & {8{global_en}};
    wire [7:0] live_hi  = live & src_hi;
    wire [7:0] live_lo  = live & ~src_hi;

    wire       hit_hi;
    wire       hit_lo;
    wire [2:0] idx_hi;
    wire [2:0] idx_lo;

    irq_poll_pick u_pick_hi (
        .req (live_hi),
        .hit (hit_hi),
        .idx (idx_hi)
    );

    irq_poll_pick u_pick_lo (
        .req (live_lo),
        .hit (hit_lo),
        .idx (idx_lo)
    );

    // Return needs no level memory: a high handler is always the newest
    reg  [1:0] in_prog_q;   // [0] low level, [1] high level

    // High beats low; low only when no handler runs at all
    wire take_hi = hit_hi & ~in_prog_q[1];
    wire take_lo = hit_lo & ~hit_hi & ~in_prog_q[1]
                 & ~in_prog_q[0];

    // Enable or priority register access in the current instruction blocks the call; power control access does not
    reg  irq_access_q;
    wire blocked = ~(mcycle_last & instr_done)
                 | irq_return_instr
                 | irq_access_q | (sfr_rd | sfr_wr) & is_irq_reg(sfr_addr);

    always @(posedge clk) begin
        if (!nrst || instr_done)
            irq_access_q <= 1'b0;
        else if ((sfr_rd | sfr_wr) & is_irq_reg(sfr_addr))
            irq_access_q <= 1'b1;
    end

    // In idle the sequencer is stopped, so the instruction gate is waived
    wire idle_on   = power_control_q[`BIT_IDLE_REQ];
    wire pd_on     = power_control_q[`BIT_POWERDOWN_REQ];
    wire poll_go   = mcyc_end & (idle_on ? 1'b1 : ~blocked)
                   & ~pd_on;
    wire grant     = poll_go & (take_hi | take_lo);

    always @* idle_wake = grant & idle_on;

    ////////////////////////////////////////////////////////////////////////
    // Call, return and in-progress state

    always @(posedge clk) begin
        if (!nrst) begin
            in_prog_q       <= 2'b00;
            long_call_instr <= 1'b0;
            call_vector     <= 16'h0000;
            call_source     <= 3'h0;
            pop_pc_two      <= 1'b0;
        end else begin
            long_call_instr <= grant;
            pop_pc_two      <= irq_return_instr & instr_done;
            if (grant) begin
                call_source <= take_hi ? idx_hi : idx_lo;
                call_vector <= vec_of(take_hi ? idx_hi : idx_lo);
                in_prog_q[take_hi] <= 1'b1;
            end
            // Most recent level retires first; plain return does nothing
            if (irq_return_instr & instr_done & ~grant) begin
                if (in_prog_q[1])
                    in_prog_q[1] <= 1'b0;
                else
                    in_prog_q[0] <= 1'b0;
            end
        end
    end

    assign push_pc_only = long_call_instr;
    assign in_progress  = in_prog_q;

    ////////////////////////////////////////////////////////////////////////
    // Restart delay after an internal reset

    reg [1:0] restart_q;
    reg       restart_wait_q;

    always @(posedge clk) begin
        if (!nrst) begin
            restart_q      <= 2'd0;
            restart_wait_q <= 1'b0;
        end else if (internal_rst) begin
            restart_q      <= 2'd0;
            restart_wait_q <= 1'b1;
        end else if (restart_wait_q && mcyc_end) begin
            if (restart_q == `RESTART_MCYCLES - 2'd1)
                restart_wait_q <= 1'b0;
            else
                restart_q <= restart_q + 2'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power and peripheral controls

    // Halt takes effect on the clock that writes the request bit, not gated by instruction completion
    // Idle keeps the clock; only power-down stops the oscillator
    assign cpu_halt  = idle_on | pd_on;
    assign osc_stop  = pd_on;
    assign pwm_disable     = pd_on;
    assign twowire_disable = pd_on;
    // Reset of a stopped part still passes; detector never gated
    assign lowvolt_detect_en     = 1'b1;
    assign lowvolt_reset_disable =
        power_control_q[`BIT_LOWVOLT_RST_DISABLE];
    assign adc_irq_en          = power_control_q[`BIT_ADC_IRQ_EN];
    assign serial1_baud_double = power_control_q[`BIT_SERIAL1_BAUD_DOUBLE];
    assign serial2_baud_double = power_control_q[`BIT_SERIAL2_BAUD_DOUBLE];
    assign serial2_rx_clk_sel  =
        power_control_q[`BIT_SERIAL2_RX_CLK_SEL];
    assign serial2_tx_clk_sel  =
        power_control_q[`BIT_SERIAL2_TX_CLK_SEL];
    // External reset width is the far side's duty; nrst is trusted
    assign cpu_run_en = ~cpu_halt & ~restart_wait_q;

endmodule // irq_priority_and_power_ctrl

`default_nettype wire

// ### tb/irq_pwr_props.sv
// Port checker for the interrupt priority and power block.
// Assumes binding onto the design top; one clock, sync reset nrst.
`timescale 1ns/1ps
`default_nettype none
`include "irq_pwr_consts.vh"
module irq_pwr_props (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [7:0]  sfr_addr,
    input wire logic [7:0]  sfr_wdata,
    input wire logic        sfr_wr,
    input wire logic [7:0]  sfr_rdata,
    input wire logic        instr_done,
    input wire logic        irq_return_instr,
    input wire logic        long_call_instr,
    input wire logic [15:0] call_vector,
    input wire logic [2:0]  call_source,
    input wire logic        push_pc_only,
    input wire logic        pop_pc_two,
    input wire logic        cpu_halt,
    input wire logic        cpu_run_en,
    input wire logic        osc_stop,
    input wire logic        pwm_disable,
    input wire logic        twowire_disable,
    input wire logic        lowvolt_detect_en,
    input wire logic        lowvolt_reset_disable,
    input wire logic        serial1_baud_double,
    input wire logic [1:0]  in_progress
);
////////////////////////////////////////////////////////////////////////////
logic [15:0] vec_exp;
always_comb begin
    case (call_source)
        `SRC_EXT0:    vec_exp = `VEC_EXT0;
        `SRC_SERIAL2: vec_exp = `VEC_SERIAL2;
        `SRC_TMR0:    vec_exp = `VEC_TMR0;
        `SRC_TWOWIRE: vec_exp = `VEC_TWOWIRE;
        `SRC_EXT1:    vec_exp = `VEC_EXT1;
        `SRC_TMR1:    vec_exp = `VEC_TMR1;
        `SRC_SERIAL1: vec_exp = `VEC_SERIAL1;
        default:      vec_exp = `VEC_TMR2;
    endcase
end
default clocking @(posedge clk); endclocking
default disable iff (!nrst);
////////////////////////////////////////////////////////////////////////////
call_spacing_a: assert property (
    long_call_instr |=> !long_call_instr [*8]) else $error("Call too soon");
push_pc_a: assert property (push_pc_only == long_call_instr)
    else $error("Push differs from call");
vector_map_a: assert property (
    long_call_instr |-> call_vector == vec_exp) else $error("Bad vector");
level_track_a: assert property (long_call_instr |->
    !$past(in_progress[1]) && in_progress > $past(in_progress))
    else $error("Call at a blocked level");
pop_cause_a: assert property (
    pop_pc_two == $past(irq_return_instr && instr_done))
    else $error("Pop without a completed return");
pop_clear_a: assert property (pop_pc_two |-> in_progress ==
    ($past(in_progress[1]) ? {1'b0, $past(in_progress[0])} : 2'b00))
    else $error("Return cleared the wrong level");
level_hold_a: assert property (
    !long_call_instr && !pop_pc_two |-> $stable(in_progress))
    else $error("Level changed without call or return");
halt_run_a: assert property (cpu_halt |-> !cpu_run_en)
    else $error("Core runs while halted");
power_down_a: assert property (osc_stop |-> !long_call_instr &&
    pwm_disable && twowire_disable && lowvolt_detect_en)
    else $error("Power-down state broken");
reg_write_a: assert property (
    sfr_wr && sfr_addr == `SFR_POWER_CONTROL |=>
    serial1_baud_double == $past(sfr_wdata[7]) &&
    lowvolt_reset_disable == $past(sfr_wdata[5]))
    else $error("Power control write lost");
unused_bits_a: assert property (
    sfr_addr == `SFR_IRQ_ENABLE_SECONDARY ||
    sfr_addr == `SFR_IRQ_PRIORITY_SECOND |->
    (sfr_rdata & ~`MASK_ENABLE_SECONDARY) == 8'h00)
    else $error("Unused bit reads one");
endmodule // irq_pwr_props
bind irq_priority_and_power_ctrl irq_pwr_props irq_pwr_props_inst (
    .clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata), .instr_done(instr_done),
    .irq_return_instr(irq_return_instr), .long_call_instr(long_call_instr),
    .call_vector(call_vector), .call_source(call_source),
    .push_pc_only(push_pc_only), .pop_pc_two(pop_pc_two),
    .cpu_halt(cpu_halt), .cpu_run_en(cpu_run_en), .osc_stop(osc_stop),
    .pwm_disable(pwm_disable), .twowire_disable(twowire_disable),
    .lowvolt_detect_en(lowvolt_detect_en),
    .lowvolt_reset_disable(lowvolt_reset_disable),
    .serial1_baud_double(serial1_baud_double), .in_progress(in_progress));
`default_nettype wire

// ### tb/seq_model.sv
// Behavioural model of the core sequencer facing the block.
// Assumes the bench steers it just after the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module seq_model (
    input  wire logic stall,
    input  wire logic ret_req,
    input  wire logic sub_req,
    output wire logic mcycle_last,
    output wire logic instr_done,
    output wire logic irq_return_instr,
    output wire logic sub_return_instr
);
// Stalled means a long instruction: no cycle is its last one
assign mcycle_last      = ~stall;
assign instr_done       = ~stall;
// Each return is a one-clock instruction while the bench holds it
assign irq_return_instr = ret_req & ~stall;
assign sub_return_instr = sub_req & ~stall;
endmodule // seq_model
`default_nettype wire

// ### tb/irq_priority_and_power_ctrl_test.sv
// Self-checking bench for the interrupt priority and power block.
// Assumes the sequencer model and port checker compile alongside.
`timescale 1ns/1ps
`default_nettype none
`include "irq_pwr_consts.vh"
module irq_priority_and_power_ctrl_test;
logic        clk, nrst, sfr_wr, sfr_rd, internal_rst, stall, ret_req, sub_req;
logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, irq_flags, r, d, en;
logic        mcycle_last, instr_done, irq_return_instr, sub_return_instr;
logic        long_call_instr, push_pc_only, pop_pc_two, cpu_halt, osc_stop;
logic        pwm_disable, twowire_disable, lowvolt_detect_en, cpu_run_en;
logic        lowvolt_reset_disable, adc_irq_en, got, sfr_hit;
logic        serial1_baud_double, serial2_baud_double;
logic        serial2_rx_clk_sel, serial2_tx_clk_sel;
logic [15:0] call_vector;
logic [2:0]  call_source;
logic [1:0]  in_progress;
logic [3:0]  p;
logic [7:0]  wv [4];
logic [7:0]  addr_tab [5] = '{`SFR_IRQ_ENABLE_PRIMARY,
    `SFR_IRQ_ENABLE_SECONDARY, `SFR_IRQ_PRIORITY_PRIMARY,
    `SFR_IRQ_PRIORITY_SECOND, `SFR_POWER_CONTROL};
logic [7:0]  mask_tab [4] = '{`MASK_ENABLE_PRIMARY, `MASK_ENABLE_SECONDARY,
    `MASK_PRIORITY_PRIMARY, `MASK_PRIORITY_SECONDARY};
integer      mismatches = 0, n_tests = 0, cycles = 0, seed, i;
////////////////////////////////////////////////////////////////////////////
irq_priority_and_power_ctrl irq_priority_and_power_ctrl_inst (
    .clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit),
    .mcycle_last(mcycle_last), .instr_done(instr_done),
    .irq_return_instr(irq_return_instr), .sub_return_instr(sub_return_instr),
    .internal_rst(internal_rst), .irq_flags(irq_flags),
    .long_call_instr(long_call_instr), .call_vector(call_vector),
    .call_source(call_source), .push_pc_only(push_pc_only),
    .pop_pc_two(pop_pc_two), .cpu_halt(cpu_halt), .osc_stop(osc_stop),
    .pwm_disable(pwm_disable), .twowire_disable(twowire_disable),
    .lowvolt_detect_en(lowvolt_detect_en),
    .lowvolt_reset_disable(lowvolt_reset_disable), .adc_irq_en(adc_irq_en),
    .serial1_baud_double(serial1_baud_double),
    .serial2_baud_double(serial2_baud_double),
    .serial2_rx_clk_sel(serial2_rx_clk_sel),
    .serial2_tx_clk_sel(serial2_tx_clk_sel),
    .cpu_run_en(cpu_run_en), .in_progress(in_progress));
seq_model seq_model_inst (.stall(stall), .ret_req(ret_req),
    .sub_req(sub_req), .mcycle_last(mcycle_last), .instr_done(instr_done),
    .irq_return_instr(irq_return_instr), .sub_return_instr(sub_return_instr));
////////////////////////////////////////////////////////////////////////////
// Enable or priority bytes regrouped into polling order
function automatic [7:0] by_poll(input [7:0] a, input [7:0] b);
    by_poll = {a[5], a[4], a[3], a[2], b[1], a[1], b[4], a[0]};
endfunction
// Lowest index wins inside a level; bit 3 set means nothing to serve
function automatic [3:0] pick(input [7:0] req, input [7:0] hi);
    integer k;
    pick = 4'h8;
    for (k = 7; k >= 0; k = k - 1) if (req[k]) pick = k[3:0];
    for (k = 7; k >= 0; k = k - 1) if (req[k] & hi[k]) pick = k[3:0];
endfunction
function automatic [15:0] vec(input [2:0] s);
    case (s)
        3'h0: vec = 16'h0003;
        3'h1: vec = 16'h004B;
        3'h2: vec = 16'h000B;
        3'h3: vec = 16'h0043;
        3'h4: vec = 16'h0013;
        3'h5: vec = 16'h001B;
        3'h6: vec = 16'h0023;
        default: vec = 16'h002B;
    endcase
endfunction
task automatic chk(input [15:0] g, input [15:0] e);
    n_tests = n_tests + 1;
    if (g !== e) begin
        mismatches = mismatches + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
endtask
task automatic wr(input [7:0] a, input [7:0] v);
    @(negedge clk);
    {sfr_addr, sfr_wdata, sfr_wr} = {a, v, 1'b1};
    @(negedge clk);
    sfr_wr = 1'b0;
endtask
task automatic rd(input [7:0] a, output [7:0] v);
    @(negedge clk);
    {sfr_addr, sfr_rd} = {a, 1'b1};
    @(posedge clk);
    v = sfr_rdata;
    @(negedge clk);
    sfr_rd = 1'b0;
endtask
// Bounded wait; the call pulse stands one cycle so every cycle is seen
task automatic wait_call(output logic g);
    integer n;
    g = 1'b0;
    for (n = 0; n < 30 && !g; n = n + 1) begin
        @(negedge clk);
        g = (long_call_instr === 1'b1);
    end
endtask
task automatic ret(input [1:0] lvl);
    // Let a fresh sample clear the stale flags before the level drops
    repeat (13) @(negedge clk);
    @(negedge clk);
    ret_req = 1'b1;
    @(negedge clk);
    ret_req = 1'b0;
    chk(pop_pc_two, 1);
    chk(in_progress, lvl);
endtask
task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
    clk = 1'b1;
    forever #2 clk = ~clk;
end
always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
        mismatches = mismatches + 1;
        close_out;
    end
end
initial begin
    seed = 32'hd5a0;
    {nrst, sfr_wr, sfr_rd, internal_rst, stall, ret_req, sub_req} = 7'h00;
    {sfr_addr, sfr_wdata, irq_flags} = 24'h000000;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    for (i = 0; i < 5; i = i + 1) begin
        rd(addr_tab[i], r);
        chk(r, 0);
        chk(sfr_hit, 1);
    end
    for (i = 0; i < 16; i = i + 1) begin
        d = $random(seed);
        wr(addr_tab[i % 4], d);
        rd(addr_tab[i % 4], r);
        chk(r, d & mask_tab[i % 4]);
        d = $random(seed) & 8'hFC;
        wr(`SFR_POWER_CONTROL, d);
        chk({serial1_baud_double, serial2_baud_double, lowvolt_reset_disable,
            adc_irq_en, serial2_rx_clk_sel, serial2_tx_clk_sel}, d[7:2]);
    end
    wr(`SFR_POWER_CONTROL, 8'h00);
    rd(8'h00, r);
    chk(r, 0);
    chk(sfr_hit, 0);
    $display("register test done");
    repeat (24) begin
        for (i = 0; i < 4; i = i + 1) begin
            wv[i] = $random(seed);
            wr(addr_tab[i], wv[i]);
        end
        irq_flags = $random(seed);
        en = wv[0][7] ? by_poll(wv[0], wv[1]) & irq_flags : 8'h00;
        p = pick(en, by_poll(wv[2], wv[3]));
        wait_call(got);
        chk(got, !p[3]);
        if (!p[3]) begin
            chk(call_vector, vec(p[2:0]));
            chk(call_source, p[2:0]);
            chk(in_progress[1],
                (by_poll(wv[2], wv[3]) >> p[2:0]) & 8'h01);
            wait_call(got);
            chk(got, 0);
            irq_flags = 8'h00;
            ret(2'b00);
        end
        irq_flags = 8'h00;
        repeat (13) @(negedge clk);
    end
    $display("arbitration test done");
    wr(`SFR_IRQ_ENABLE_PRIMARY, 8'hA1);
    wr(`SFR_IRQ_PRIORITY_PRIMARY, 8'h20);
    wr(`SFR_IRQ_PRIORITY_SECOND, 8'h00);
    irq_flags = 8'h01;
    wait_call(got);
    chk(call_vector, `VEC_EXT0);
    @(negedge clk);
    sub_req = 1'b1;
    @(negedge clk);
    sub_req = 1'b0;
    chk(in_progress, 2'b01);
    irq_flags = 8'h81;
    wait_call(got);
    chk(call_vector, `VEC_TMR2);
    chk(in_progress, 2'b11);
    wait_call(got);
    chk(got, 0);
    irq_flags = 8'h00;
    ret(2'b01);
    ret(2'b00);
    $display("preemption test done");
    stall = 1'b1;
    irq_flags = 8'h01;
    wait_call(got);
    chk(got, 0);
    irq_flags = 8'h00;
    repeat (30) @(negedge clk);
    stall = 1'b0;
    wait_call(got);
    chk(got, 0);
    {sfr_addr, sfr_rd, irq_flags} = {`SFR_IRQ_ENABLE_PRIMARY, 9'h101};
    wait_call(got);
    chk(got, 0);
    sfr_rd = 1'b0;
    wait_call(got);
    chk(got, 1);
    irq_flags = 8'h00;
    ret(2'b00);
    $display("blocking test done");
    wr(`SFR_POWER_CONTROL, 8'h01);
    chk({cpu_halt, cpu_run_en}, 2'b10);
    irq_flags = 8'h01;
    wait_call(got);
    chk(got, 1);
    @(negedge clk);
    chk(cpu_halt, 0);
    irq_flags = 8'h00;
    ret(2'b00);
    wr(`SFR_POWER_CONTROL, 8'h02);
    chk({osc_stop, pwm_disable, twowire_disable}, 3'h7);
    irq_flags = 8'h01;
    wait_call(got);
    chk({got, lowvolt_detect_en}, 2'b01);
    irq_flags = 8'h00;
    nrst = 1'b0;
    repeat (24) @(negedge clk);
    nrst = 1'b1;
    rd(`SFR_POWER_CONTROL, r);
    chk({r, osc_stop}, 9'h000);
    internal_rst = 1'b1;
    @(negedge clk);
    internal_rst = 1'b0;
    repeat (30) @(negedge clk);
    chk(cpu_run_en, 0);
    repeat (20) @(negedge clk);
    chk(cpu_run_en, 1);
    $display("power test done");
    close_out;
end
endmodule // irq_priority_and_power_ctrl_test
`default_nettype wire
